// [src/sccx_exec.sv]
// Execution unit for bit-skip, calls, clears, watchdog kick, invert, decrement
//
// Contract
// - Skip-when-one with bit set discards next instruction; two cycles total.
// - Immediate call pushes PC plus one before PC changes.
// - Immediate call loads literal to PC[10:0], latch[6:3] to PC[14:11].
// - Immediate call takes two cycles and changes no status flag.
// - Accumulator call pushes PC plus one, loads accumulator and latch[6:0].
// - Accumulator call takes two cycles and changes no status flag.
// - Zero file register writes zero to addressed register, sets zero flag.
// - Zero accumulator writes zero to accumulator, sets zero flag.
// - Watchdog kick clears watchdog counter and its prescaler.
// - Watchdog kick sets both active-low expired and sleep flags only.
// - Invert file register to accumulator or register by destination; zero flag.
// - Decrement file register to accumulator or register by destination; zero flag.
`timescale 1ns/1ns
`default_nettype none
module sccx_exec
    import sccx_pkg::*;
#(
    parameter int STACK_D = STACK_DEPTH, // Return stack depth
    parameter int WDT_BITS = WDT_W,      // Watchdog counter width
    parameter int PRE_BITS = PRE_W       // Watchdog prescaler width
) (
    input  wire logic              pclk,          // Core clock
    input  wire logic              presetn,       // Async reset, active low
    input  wire logic              ce,            // Clock enable
    input  wire logic              psel,          // APB select
    input  wire logic              penable,       // APB enable
    input  wire logic              pwrite,        // APB direction
    input  wire logic [7:0]        paddr,         // APB byte address
    input  wire logic [31:0]       pwdata,        // APB write data
    output logic      [31:0]       prdata,        // APB read data
    output logic                   pready,        // APB ready
    output logic                   pslverr,       // APB error
    input  wire logic              instr_valid,   // Decoded instruction valid
    input  wire sccx_instr_s       instr,         // Decoded instruction
    output logic                   instr_ready,   // Instruction taken
    input  wire logic              wdt_tick,      // Watchdog prescaler tick
    input  wire logic              wdt_expire,    // Watchdog timeout event
    input  wire logic              sleep_enter,   // Sleep entry event
    output logic      [PC_W-1:0]   pc_out,        // Program counter
    output logic                   watchdog_kick_o // Kick seen last cycle
);
    // ========================================================================
    // State
    // ========================================================================
    logic [7:0]          file_mem [FILE_DEPTH];
    logic [PC_W-1:0]     stack_mem [STACK_D];
    logic [$clog2(STACK_D)-1:0] sp_reg;
    logic [7:0]          accum_reg;
    logic [LATCH_W-1:0]  program_counter_high_latch_reg;
    logic [PC_W-1:0]     pc_reg;
    logic [PC_W-1:0]     call_target_reg;
    logic                zero_flag_reg;
    logic                watchdog_expired_n_flag_reg;
    logic                sleep_entered_n_flag_reg;
    logic                skip_reg;
    sccx_state_e         state_reg;
    logic [WDT_BITS-1:0] watchdog_counter_reg;
    logic [PRE_BITS-1:0] prescaler_reg;
    logic [FADDR_W-1:0]  file_addr_reg;

    // ========================================================================
    // Instruction decode
    // ========================================================================
    logic       accept;
    logic       live;
    logic [7:0] fdata;
    logic [7:0] inv_val;
    logic [7:0] dec_val;
    logic       is_file_op;
    logic [7:0] alu_val;

    // Taken only when ready and not mid-call
    assign accept     = ce && instr_valid && instr_ready && state_reg == ST_EXEC;
    assign live       = accept && !skip_reg;
    assign fdata      = file_mem[instr.faddr];
    assign inv_val    = ~fdata;
    assign dec_val    = fdata - 8'h01;
    assign is_file_op = instr.op == OP_INV_F || instr.op == OP_DEC_F;
    assign alu_val    = (instr.op == OP_INV_F) ? inv_val : dec_val;

    // APB decode
    logic apb_wr;
    logic apb_hit;
    // Writes land at the access edge; unmapped ones are dropped
    assign apb_wr  = ce && psel && penable && pready && pwrite && !pslverr;
    always_comb begin
        case (paddr)
            OFF_ACCUM, OFF_STATUS, OFF_PC, OFF_LATCH, OFF_STACK_TOP,
            OFF_WATCHDOG, OFF_FILE_ADDR, OFF_FILE_DATA: apb_hit = 1'b1;
            default: apb_hit = 1'b0;
        endcase
    end

    // ========================================================================
    // Sequencer
    // ========================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg   <= ST_EXEC;
            instr_ready <= 1'b1;
        end else if (ce) begin
            case (state_reg)
                ST_EXEC: begin
                    if (live && (instr.op == OP_CALL_IMM || instr.op == OP_CALL_ACC)) begin
                        state_reg   <= ST_CALL2;
                        instr_ready <= 1'b0;
                    end
                end
                ST_CALL2: begin
                    state_reg   <= ST_EXEC;
                    instr_ready <= 1'b1;
                end
                default: begin
                    state_reg   <= ST_EXEC;
                    instr_ready <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            skip_reg <= 1'b0;
        end else if (accept) begin
            // Discarded skip test never arms a new skip
            skip_reg <= !skip_reg && instr.op == OP_BIT_SKIP1 && fdata[instr.bitsel];
        end
    end

    // ========================================================================
    // Program counter and call target
    // ========================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_reg          <= PC_RST;
            call_target_reg <= PC_RST;
        end else if (ce) begin
            // Second call cycle jumps to the held target
            if (state_reg == ST_CALL2) begin
                pc_reg <= call_target_reg;
            end else if (accept) begin
                pc_reg <= pc_reg + 15'h0001;
                if (live && instr.op == OP_CALL_IMM) begin
                    call_target_reg <= {program_counter_high_latch_reg[6:3], instr.lit};
                    pc_reg          <= pc_reg;
                end
                if (live && instr.op == OP_CALL_ACC) begin
                    call_target_reg <= {program_counter_high_latch_reg, accum_reg};
                    pc_reg          <= pc_reg;
                end
            end
        end
    end
    assign pc_out = pc_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_reg <= '0;
        end else if (live && (instr.op == OP_CALL_IMM || instr.op == OP_CALL_ACC)) begin
            sp_reg <= sp_reg + 1'b1;
        end
    end

    always_ff @(posedge pclk) begin
        if (live && (instr.op == OP_CALL_IMM || instr.op == OP_CALL_ACC)) begin
            // Push lands one slot above the top; wraps
            stack_mem[sp_reg + 1'b1] <= pc_reg + 15'h0001;
        end
    end

    // ========================================================================
    // Accumulator
    // ========================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accum_reg <= ZERO_BYTE;
        end else if (ce) begin
            if (apb_wr && paddr == OFF_ACCUM) begin
                accum_reg <= pwdata[7:0];
            end
            if (live && instr.op == OP_ZERO_W) begin
                accum_reg <= ZERO_BYTE;
            end
            if (live && is_file_op && !instr.dest) begin
                accum_reg <= alu_val;
            end
        end
    end

    // ========================================================================
    // File registers
    // ========================================================================
    always_ff @(posedge pclk) begin
        if (ce) begin
            if (apb_wr && paddr == OFF_FILE_DATA) begin
                file_mem[file_addr_reg] <= pwdata[7:0];
            end
            // Instruction write wins over bus write
            // zero file register
            if (live && instr.op == OP_ZERO_F) begin
                file_mem[instr.faddr] <= ZERO_BYTE;
            end
            if (live && is_file_op && instr.dest) begin
                file_mem[instr.faddr] <= alu_val;
            end
        end
    end

    // ========================================================================
    // Status flags
    // ========================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zero_flag_reg <= 1'b0;
        end else if (live) begin
            if (instr.op == OP_ZERO_F || instr.op == OP_ZERO_W) begin
                zero_flag_reg <= 1'b1;
            end
            if (is_file_op) begin
                zero_flag_reg <= alu_val == ZERO_BYTE;
            end
        end
    end

    // kick sets both flags, kick wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_expired_n_flag_reg <= 1'b1;
            sleep_entered_n_flag_reg    <= 1'b1;
        end else if (ce) begin
            if (live && instr.op == OP_WDT_KICK) begin
                watchdog_expired_n_flag_reg <= 1'b1;
                sleep_entered_n_flag_reg    <= 1'b1;
            end else begin
                if (wdt_expire) begin
                    watchdog_expired_n_flag_reg <= 1'b0;
                end
                if (sleep_enter) begin
                    sleep_entered_n_flag_reg <= 1'b0;
                end
            end
        end
    end

    // ========================================================================
    // Watchdog counter
    // ========================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_counter_reg <= '0;
            prescaler_reg        <= '0;
            watchdog_kick_o      <= 1'b0;
        end else if (ce) begin
            watchdog_kick_o <= live && instr.op == OP_WDT_KICK;
            if (live && instr.op == OP_WDT_KICK) begin
                watchdog_counter_reg <= '0;
                prescaler_reg        <= '0;
            end else if (wdt_tick) begin
                prescaler_reg <= prescaler_reg + 1'b1;
                // Prescaler wrap advances the counter
                if (&prescaler_reg) begin
                    watchdog_counter_reg <= watchdog_counter_reg + 1'b1;
                end
            end
        end
    end

    // ========================================================================
    // APB slave: latch and file pointer
    // ========================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_counter_high_latch_reg <= '0;
            file_addr_reg                  <= '0;
        end else if (apb_wr) begin
            if (paddr == OFF_LATCH) begin
                program_counter_high_latch_reg <= pwdata[LATCH_W-1:0];
            end
            if (paddr == OFF_FILE_ADDR) begin
                file_addr_reg <= pwdata[FADDR_W-1:0];
            end
        end
    end

    // Answer registered in setup cycle, ready in the access cycle
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            OFF_ACCUM:     rd_mux[7:0] = accum_reg;
            OFF_STATUS: begin
                rd_mux[ST_ZERO] = zero_flag_reg;
                rd_mux[ST_TO_N] = watchdog_expired_n_flag_reg;
                rd_mux[ST_PD_N] = sleep_entered_n_flag_reg;
                rd_mux[ST_SKIP] = skip_reg;
                rd_mux[ST_BUSY] = state_reg == ST_CALL2;
            end
            OFF_PC:        rd_mux[PC_W-1:0] = pc_reg;
            OFF_LATCH:     rd_mux[LATCH_W-1:0] = program_counter_high_latch_reg;
            OFF_STACK_TOP: rd_mux[PC_W-1:0] = stack_mem[sp_reg];
            OFF_WATCHDOG: begin
                rd_mux[WDT_BITS-1:0]                   = watchdog_counter_reg;
                rd_mux[WD_PRE_LSB +: PRE_BITS]         = prescaler_reg;
            end
            OFF_FILE_ADDR: rd_mux[FADDR_W-1:0] = file_addr_reg;
            OFF_FILE_DATA: rd_mux[7:0] = file_mem[file_addr_reg];
            default:       rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (ce) begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !apb_hit;
            if (psel && !penable && !pwrite) begin
                prdata <= rd_mux;
            end
        end
    end
endmodule : sccx_exec
`default_nettype wire

// [src/sccx_pkg.sv]
// Shared types and constants for the skip/call/clear/complement execution slice
package sccx_pkg;
    // ========================================================================
    // Widths and reset values
    // ========================================================================
    localparam int         PC_W        = 15;
    localparam int         LIT_W       = 11;
    localparam int         LATCH_W     = 7;
    localparam int         FADDR_W     = 7;
    localparam int         FILE_DEPTH  = 128;
    localparam int         STACK_DEPTH = 16;
    localparam int         WDT_W       = 8;
    localparam int         PRE_W       = 8;
    localparam logic [7:0] ZERO_BYTE   = 8'h00;
    localparam logic [PC_W-1:0] PC_RST = 15'h0000;

    // ========================================================================
    // Register map (byte addresses)
    // ========================================================================
    localparam logic [7:0] OFF_ACCUM     = 8'h00;
    localparam logic [7:0] OFF_STATUS    = 8'h04;
    localparam logic [7:0] OFF_PC        = 8'h08;
    localparam logic [7:0] OFF_LATCH     = 8'h0c;
    localparam logic [7:0] OFF_STACK_TOP = 8'h10;
    localparam logic [7:0] OFF_WATCHDOG  = 8'h14;
    localparam logic [7:0] OFF_FILE_ADDR = 8'h18;
    localparam logic [7:0] OFF_FILE_DATA = 8'h1c;

    // Status register bit positions
    localparam int ST_ZERO  = 0;
    localparam int ST_TO_N  = 1;
    localparam int ST_PD_N  = 2;
    localparam int ST_SKIP  = 3;
    localparam int ST_BUSY  = 4;
    // Watchdog register: counter in low byte, prescaler in next byte
    localparam int WD_PRE_LSB = 8;

    // ========================================================================
    // Operations and sequencer states
    // ========================================================================
    typedef enum logic [3:0] {
        OP_NOP        = 4'h0,
        OP_BIT_SKIP1  = 4'h1,
        OP_CALL_IMM   = 4'h2,
        OP_CALL_ACC   = 4'h3,
        OP_ZERO_F     = 4'h4,
        OP_ZERO_W     = 4'h5,
        OP_WDT_KICK   = 4'h6,
        OP_INV_F      = 4'h7,
        OP_DEC_F      = 4'h8
    } sccx_op_e;

    typedef enum logic [0:0] {
        ST_EXEC  = 1'b0,
        ST_CALL2 = 1'b1
    } sccx_state_e;

    typedef struct packed {
        sccx_op_e             op;
        logic [FADDR_W-1:0]   faddr;
        logic [2:0]           bitsel;
        logic                 dest;
        logic [LIT_W-1:0]     lit;
    } sccx_instr_s;
endpackage : sccx_pkg

// [test/sccx_exec_checker.sv]
// Port-level assertions for the execution slice
`timescale 1ns/1ns
`default_nettype none
module sccx_exec_checker
    import sccx_pkg::*;
(
    input wire logic            pclk,           // Clock
    input wire logic            presetn,        // Reset, active low
    input wire logic            ce,             // Clock enable
    input wire logic            psel,           // APB select
    input wire logic            penable,        // APB enable
    input wire logic            pwrite,         // APB direction
    input wire logic [31:0]     prdata,         // APB read data
    input wire logic            pready,         // APB ready
    input wire logic            pslverr,        // APB error
    input wire logic            instr_valid,    // Instruction offered
    input wire sccx_instr_s     instr,          // Instruction
    input wire logic            instr_ready,    // Instruction taken
    input wire logic [PC_W-1:0] pc_out,         // Program counter
    input wire logic            watchdog_kick_o // Kick pulse
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic take;
    logic call_op;
    logic after_skip_reg;
    assign take = ce && instr_valid && instr_ready;
    assign call_op = take && (instr.op == OP_CALL_IMM || instr.op == OP_CALL_ACC);
    // ========================================================================
    // Follower of a skip test may be discarded
    // ========================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            after_skip_reg <= 1'b0;
        end else if (take) begin
            after_skip_reg <= (instr.op == OP_BIT_SKIP1);
        end
    end
    // ========================================================================
    // Properties
    // ========================================================================
    sequence s_call_hold;
        !instr_ready && $stable(pc_out);
    endsequence
    sequence s_call_done;
        instr_ready;
    endsequence
    property p_call_two;
        call_op && !after_skip_reg |=> s_call_hold ##1 s_call_done;
    endproperty
    property p_call_lit;
        call_op && !after_skip_reg && instr.op == OP_CALL_IMM
            |=> s_call_hold ##1 (pc_out[10:0] == $past(instr.lit, 2));
    endproperty
    property p_step;
        take && !call_op |=> pc_out == $past(pc_out) + 15'h1;
    endproperty
    property p_idle;
        instr_ready && !(ce && instr_valid) |=> $stable(pc_out);
    endproperty
    property p_ready_drop;
        $fell(instr_ready) |-> $past(call_op);
    endproperty
    property p_kick;
        watchdog_kick_o |-> $past(take && instr.op == OP_WDT_KICK);
    endproperty
    property p_apb_rdy;
        ce && psel && !penable |=> pready;
    endproperty
    property p_no_rdy;
        ce && !(psel && !penable) |=> !pready;
    endproperty
    property p_err;
        pslverr |-> pready;
    endproperty
    property p_rdata;
        !(ce && psel && !penable && !pwrite) |=> $stable(prdata);
    endproperty
    a_call_two: assert property (p_call_two) else $error("call length wrong");
    a_call_lit: assert property (p_call_lit) else $error("call target wrong");
    a_step: assert property (p_step) else $error("pc did not advance by one");
    a_idle: assert property (p_idle) else $error("pc moved while idle");
    a_ready_drop: assert property (p_ready_drop) else $error("stall without call");
    a_kick: assert property (p_kick) else $error("kick pulse without kick");
    a_apb_rdy: assert property (p_apb_rdy) else $error("no ready after setup");
    a_no_rdy: assert property (p_no_rdy) else $error("ready without setup");
    a_err: assert property (p_err) else $error("error without ready");
    a_rdata: assert property (p_rdata) else $error("read data changed");
endmodule : sccx_exec_checker
`default_nettype wire

// [test/tb_top.sv]
// Self-checking testbench for the execution slice
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import sccx_pkg::*;
;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] m; logic e;} sccx_note_s;
    logic            pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
    logic            psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]      paddr = 8'h00;
    logic [31:0]     pwdata = 32'h0;
    logic            instr_valid = 1'b0, wdt_tick = 1'b0, wdt_expire = 1'b0, sleep_enter = 1'b0;
    sccx_instr_s     instr = '0;
    logic [31:0]     prdata;
    logic            pready, pslverr, instr_ready, watchdog_kick_o;
    logic [PC_W-1:0] pc_out, pc_m, tos_m;
    logic [7:0]      acc_m, v, fm [FILE_DEPTH];
    logic [15:0]     wd_m;
    logic [6:0]      lat_m, f;
    logic [2:0]      b;
    logic            z_m, to_m, pd_m, skp;
    int              n_fail = 0, total_checks = 0, i;
    integer          seed = 32'h93d3;
    sccx_note_s      notes [$];
    sccx_note_s      nt;
    sccx_op_e        fol [4] = '{OP_ZERO_W, OP_CALL_IMM, OP_INV_F, OP_ZERO_F};

    sccx_exec sccx_exec_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .instr_valid(instr_valid), .instr(instr),
        .instr_ready(instr_ready), .wdt_tick(wdt_tick), .wdt_expire(wdt_expire),
        .sleep_enter(sleep_enter), .pc_out(pc_out), .watchdog_kick_o(watchdog_kick_o));

    always #5 pclk = ~pclk;
    // ========================================================================
    // Compare and verdict
    // ========================================================================
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (e !== g) begin
            n_fail++;
            $display("MISMATCH %s exp %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            if (notes.size() == 0) begin
                chk("unexpected answer", 32'h0, 32'h1);
            end else begin
                nt = notes.pop_front();
                chk($sformatf("prdata at %h", nt.a), nt.d & nt.m, prdata & nt.m);
                chk($sformatf("pslverr at %h", nt.a), {31'h0, nt.e}, {31'h0, pslverr});
            end
        end
    end
    initial begin
        #100000;
        n_fail++;
        conclude();
    end
    // ========================================================================
    // APB master and instruction driver
    // ========================================================================
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m, input logic e);
        int t;
        t = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        notes.push_back('{a, d, m, e});
        @(posedge pclk);
        penable <= 1'b1;
        do begin @(posedge pclk); t++; end while (pready !== 1'b1 && t < 50);
        if (pready !== 1'b1) n_fail++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 1'b0);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        apb(1'b0, a, d, 32'hffffffff, 1'b0);
    endtask : rd
    task automatic setf(input logic [6:0] a, input logic [7:0] d);
        wr(OFF_FILE_ADDR, {25'h0, a});
        wr(OFF_FILE_DATA, {24'h0, d});
        fm[a] = d;
    endtask : setf
    task automatic rdf(input logic [6:0] a);
        wr(OFF_FILE_ADDR, {25'h0, a});
        rd(OFF_FILE_DATA, {24'h0, fm[a]});
    endtask : rdf
    task automatic st;
        rd(OFF_ACCUM, {24'h0, acc_m});
        rd(OFF_STATUS, {27'h0, 1'b0, skp, pd_m, to_m, z_m});
        rd(OFF_PC, {17'h0, pc_m});
        rd(OFF_STACK_TOP, {17'h0, tos_m});
    endtask : st
    task automatic op(input sccx_op_e o, input logic [6:0] a, input logic [2:0] s,
                      input logic d, input logic [10:0] k);
        int t;
        logic [7:0] r;
        t = 0;
        @(posedge pclk);
        instr_valid <= 1'b1;
        instr <= '{o, a, s, d, k};
        do begin @(posedge pclk); t++; end while (instr_ready !== 1'b1 && t < 50);
        if (instr_ready !== 1'b1) n_fail++;
        instr_valid <= 1'b0;
        if (skp) begin
            skp = 1'b0;
            pc_m++;
        end else begin
            tos_m = (o == OP_CALL_IMM || o == OP_CALL_ACC) ? pc_m + 15'h1 : tos_m;
            pc_m = (o == OP_CALL_IMM) ? {lat_m[6:3], k} :
                   (o == OP_CALL_ACC) ? {lat_m, acc_m} : pc_m + 15'h1;
            r = (o == OP_INV_F) ? ~fm[a] : fm[a] - 8'h01;
            case (o)
                OP_BIT_SKIP1: skp = fm[a][s];
                OP_ZERO_F: {fm[a], z_m} = {8'h00, 1'b1};
                OP_ZERO_W: {acc_m, z_m} = {8'h00, 1'b1};
                OP_WDT_KICK: {wd_m, to_m, pd_m} = {16'h0, 2'b11};
                OP_INV_F, OP_DEC_F: begin
                    z_m = (r == 8'h00);
                    if (d) fm[a] = r;
                    else acc_m = r;
                end
                default: ;
            endcase
        end
    endtask : op
    // ========================================================================
    // Main sequence
    // ========================================================================
    initial begin
        {pc_m, acc_m, lat_m, z_m, to_m, pd_m, skp, wd_m} = {15'h0, 8'h0, 7'h0, 4'b0110, 16'h0};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFF_STATUS, 32'h6);
        rd(OFF_PC, 32'h0);
        rd(OFF_WATCHDOG, 32'h0);
        rd(OFF_LATCH, 32'h0);
        apb(1'b0, 8'h20, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 8'h24, 32'h0, 32'h0, 1'b1);
        lat_m = $random(seed);
        acc_m = $random(seed) | 8'h01;
        wr(OFF_LATCH, {25'h0, lat_m});
        wr(OFF_ACCUM, {24'h0, acc_m});
        op(OP_ZERO_W, 7'h0, 3'h0, 1'b0, 11'h0);
        rd(OFF_ACCUM, {24'h0, acc_m});
        rd(OFF_STATUS, 32'h7);
        acc_m = $random(seed);
        wr(OFF_ACCUM, {24'h0, acc_m});
        op(OP_CALL_IMM, 7'h0, 3'h0, 1'b0, 11'h7ff);
        st();
        op(OP_CALL_ACC, 7'h0, 3'h0, 1'b0, 11'h0);
        op(OP_CALL_IMM, 7'h0, 3'h0, 1'b0, $random(seed));
        st();
        op(OP_CALL_ACC, 7'h0, 3'h0, 1'b0, 11'h0);
        st();
        for (i = 0; i < 8; i++) begin
            f = $random(seed);
            v = i[2] ? (i[0] ? 8'h00 : $random(seed)) : (i[0] ? 8'h01 : 8'hff);
            setf(f, v);
            op(i[0] ? OP_DEC_F : OP_INV_F, f, 3'h0, i[1], 11'h0);
            rdf(f);
            st();
        end
        setf(7'h7f, 8'ha5);
        op(OP_ZERO_F, 7'h7f, 3'h0, 1'b0, 11'h0);
        rdf(7'h7f);
        st();
        wd_m = {2'b00, 6'($random(seed)) | 6'h01, 8'h00};
        @(posedge pclk);
        wdt_tick <= 1'b1;
        ce <= 1'b0;
        repeat (3) @(posedge pclk);
        ce <= 1'b1;
        repeat (wd_m[15:8]) @(posedge pclk);
        wdt_tick <= 1'b0;
        wdt_expire <= 1'b1;
        @(posedge pclk);
        wdt_expire <= 1'b0;
        sleep_enter <= 1'b1;
        @(posedge pclk);
        sleep_enter <= 1'b0;
        {to_m, pd_m} = 2'b00;
        rd(OFF_WATCHDOG, {16'h0, wd_m});
        st();
        op(OP_WDT_KICK, 7'h0, 3'h0, 1'b0, 11'h0);
        rd(OFF_WATCHDOG, 32'h0);
        st();
        for (i = 0; i < 8; i++) begin
            f = $random(seed);
            b = $random(seed);
            v = $random(seed);
            v[b] = i[2];
            setf(f, v);
            op(OP_BIT_SKIP1, f, b, 1'b0, 11'h0);
            rd(OFF_STATUS, {27'h0, 1'b0, skp, pd_m, to_m, z_m});
            op(fol[i % 4], f, 3'h0, 1'b0, $random(seed));
            rdf(f);
            st();
        end
        conclude();
    end
endmodule : tb_top

bind sccx_exec sccx_exec_checker sccx_exec_checker_i (.pclk(pclk), .presetn(presetn),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .pc_out(pc_out), .watchdog_kick_o(watchdog_kick_o));
`default_nettype wire
